// ==== bench/dipc_top_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module dipc_top_asserts #(
	parameter int LP_WAKE_CYC = 4
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic por_rst,
	input wire logic [3:0] reg_addr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire dipc_pkg::dipc_evt_t evt,
	input wire logic cpu_clk_en,
	input wire logic cpu_cycle_en,
	input wire logic periph_clk_en,
	input wire logic regulator_low_power,
	input wire logic wdt_reset_block
);
	import dipc_pkg::*;
	default clocking @(posedge mclk); endclocking
	default disable iff (rst || por_rst);
	// Regulator must settle before any clock returns
	sequence lp_stall;
		(!cpu_clk_en && !periph_clk_en) [*3];
	endsequence
	a_rc_read: assert property (reg_rd && reg_addr == 4'h0
		|=> reg_rdata[7:2] == 6'h00 && reg_rdata[0]) else $error("rc read bits");
	a_dz_read: assert property (reg_rd && reg_addr == 4'h1
		|=> !reg_rdata[3]) else $error("dz bit3");
	a_lp_sleep: assert property (regulator_low_power
		|-> !periph_clk_en && !cpu_clk_en) else $error("lp outside sleep");
	a_idle_clocks: assert property (wdt_reset_block
		|-> periph_clk_en && !cpu_clk_en) else $error("idle clocks");
	a_idle_irq: assert property (wdt_reset_block && evt.irq_pending
		|=> !wdt_reset_block) else $error("idle irq");
	a_idle_wdt: assert property (wdt_reset_block && evt.wdt_timeout
		|=> !wdt_reset_block) else $error("idle wdt");
	a_lp_wake: assert property ($fell(regulator_low_power)
		|-> lp_stall ##[1:8] cpu_clk_en) else $error("lp wake");
	a_cycle_gap: assert property (cpu_cycle_en
		|=> !cpu_cycle_en [*3]) else $error("cycle gap");
endmodule
bind dipc_top dipc_top_asserts #(.LP_WAKE_CYC(LP_WAKE_CYC)) u_chk (.*);
`default_nettype wire

// ==== bench/tb_dipc_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_dipc_top;
	import dipc_pkg::*;
	logic mclk = 0, rst = 1, por_rst = 1, reg_wr = 0, reg_rd = 0;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00, reg_rdata;
	dipc_evt_t evt = '0;
	logic cpu_clk_en, cpu_cycle_en, periph_clk_en, regulator_low_power, wdt_reset_block;
	logic wake_pulse;
	int n_fail = 0, samples_checked = 0, cyc = 0, c;
	dipc_top #(.LP_WAKE_CYC(4)) uut (.mclk(mclk), .rst(rst), .por_rst(por_rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .evt(evt), .cpu_clk_en(cpu_clk_en), .cpu_cycle_en(cpu_cycle_en),
		.periph_clk_en(periph_clk_en), .regulator_low_power(regulator_low_power),
		.wdt_reset_block(wdt_reset_block), .wake_pulse(wake_pulse));
	always #2.5 mclk = ~mclk;
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		samples_checked++;
		if (s !== e) begin
			n_fail++;
			$display("mismatch at %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, e);
	endtask
	// Event index: 0 debug, 1 wdt, 2 return, 3 irq entry, 4 irq, 5 sleep
	task automatic ev(input int i);
		@(posedge mclk);
		evt[i] <= 1'b1;
		@(posedge mclk);
		evt[i] <= 1'b0;
		#1;
	endtask
	task automatic cnt(input int n);
		c = 0;
		repeat (n) begin
			@(posedge mclk);
			#1;
			if (cpu_cycle_en === 1'b1) c++;
		end
	endtask
	task automatic wait_run();
		repeat (20) if (cpu_clk_en !== 1'b1) @(posedge mclk);
		#1 chk(8'(cpu_clk_en), 8'h01);
	endtask
	// Longest stretch is the ratio sweep, about 10200 cycles
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			n_fail++;
			final_report();
		end
	end
	initial begin
		repeat (8) @(posedge mclk);
		rst <= 1'b0;
		por_rst <= 1'b0;
		rd(4'h0, 8'h01);
		rd(4'h1, 8'h00);
		wr(4'h0, 8'hff);
		rd(4'h0, 8'h03);
		wr(4'h1, 8'hff);
		rd(4'h1, 8'hf7);
		$display("test registers done");
		wr(4'h1, 8'h00);
		cnt(16);
		chk(8'(c), 8'h04);
		for (int r = 0; r < 8; r++) begin
			wr(4'h1, 8'h40 | 8'(r));
			cnt(8 << r);
			cnt(32 << r);
			chk(8'(c), 8'h04);
		end
		wr(4'h1, 8'h60);
		ev(3);
		rd(4'h1, 8'h20);
		wr(4'h1, 8'h10);
		ev(2);
		rd(4'h1, 8'h50);
		wr(4'h1, 8'h40);
		ev(3);
		ev(2);
		rd(4'h1, 8'h40);
		$display("test doze done");
		wr(4'h0, 8'h01);
		wr(4'h1, 8'he0);
		ev(5);
		chk(8'({wdt_reset_block, periph_clk_en, cpu_clk_en}), 8'h06);
		ev(4);
		chk(8'(wake_pulse), 8'h01);
		wait_run();
		ev(5);
		ev(1);
		wait_run();
		rd(4'h1, 8'he0);
		$display("test idle done");
		wr(4'h1, 8'h00);
		wr(4'h0, 8'h03);
		ev(5);
		chk(8'({regulator_low_power, periph_clk_en, cpu_clk_en}), 8'h04);
		ev(4);
		chk(8'(cpu_clk_en), 8'h00);
		wait_run();
		wr(4'h0, 8'h01);
		ev(5);
		chk(8'({regulator_low_power, periph_clk_en, cpu_clk_en}), 8'h00);
		ev(4);
		chk(8'(cpu_clk_en), 8'h01);
		$display("test sleep done");
		wr(4'h1, 8'hc0);
		@(posedge mclk);
		rst <= 1'b1;
		@(posedge mclk);
		rst <= 1'b0;
		rd(4'h1, 8'h80);
		wr(4'h1, 8'h47);
		ev(0);
		rd(4'h2, 8'h04);
		cnt(16);
		chk(8'(c), 8'h04);
		rd(4'h1, 8'h47);
		@(posedge mclk);
		por_rst <= 1'b1;
		@(posedge mclk);
		por_rst <= 1'b0;
		rd(4'h1, 8'h00);
		$display("test resets done");
		final_report();
	end
endmodule
`default_nettype wire

// ==== hdl/dipc_doze_div.sv ====
`timescale 1ns/1ps
`default_nettype none
module dipc_doze_div (
	input wire logic mclk,
	input wire logic rst,
	input wire logic periph_tick,
	input wire logic doze_on,
	input wire logic [2:0] ratio,
	output logic cycle_en
);
	logic [7:0] cnt_q;
	logic [7:0] limit;

	// Ratio code n selects one CPU cycle per 2^(n+1) peripheral cycles
	assign limit = 8'((9'h002 << ratio) - 9'h001);

	always_ff @(posedge mclk) begin
		if (rst || !doze_on) begin
			cnt_q <= 8'h00;
		end else if (periph_tick) begin
			cnt_q <= (cnt_q >= limit) ? 8'h00 : cnt_q + 8'h01;
		end
	end

	assign cycle_en = periph_tick && (!doze_on || cnt_q == 8'h00);
endmodule
`default_nettype wire

// ==== hdl/dipc_pkg.sv ====
package dipc_pkg;
	// Register indices on the plain register port
	localparam logic [3:0] DIPC_ADDR_REG_CTRL = 4'h0;
	localparam logic [3:0] DIPC_ADDR_DOZE_IDLE = 4'h1;
	localparam logic [3:0] DIPC_ADDR_STATUS = 4'h2;
	// Regulator control field positions
	localparam int DIPC_REG_LP_BIT = 1;
	localparam int DIPC_REG_ONE_BIT = 0;
	// Doze and idle field positions
	localparam int DIPC_IDLE_BIT = 7;
	localparam int DIPC_DOZE_BIT = 6;
	localparam int DIPC_RECOVER_BIT = 5;
	localparam int DIPC_RETURN_BIT = 4;
	localparam int DIPC_RATIO_LSB = 0;
	// Reset values
	localparam logic [7:0] DIPC_REG_CTRL_RST = 8'h01;
	localparam logic [7:0] DIPC_DOZE_IDLE_RST = 8'h00;
	// Stabilisation wait after low-power sleep, in ns
	localparam int DIPC_LP_WAKE_NS = 10000;
	localparam int DIPC_CLK_NS = 5;
	localparam int DIPC_LP_WAKE_CYC = (DIPC_LP_WAKE_NS + DIPC_CLK_NS - 1) / DIPC_CLK_NS;
	// Last system-clock phase of the four-clock peripheral instruction cycle
	localparam logic [1:0] DIPC_PHASE_LAST = 2'h3;

	typedef enum logic [1:0] {
		DIPC_RUN = 2'b00,
		DIPC_IDLE = 2'b01,
		DIPC_SLEEP = 2'b11,
		DIPC_WAKE = 2'b10
	} dipc_state_t;

	typedef struct packed {
		logic idle_select;
		logic doze_active;
		logic recover_on_irq;
		logic doze_on_return;
		logic [2:0] ratio;
	} dipc_ctrl_t;

	typedef struct packed {
		logic sleep_op;
		logic irq_pending;
		logic irq_entry;
		logic return_from_irq_op;
		logic wdt_timeout;
		logic in_circuit_debug_entry;
	} dipc_evt_t;
endpackage

// ==== hdl/dipc_top.sv ====
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Regulator low-power select set puts regulator and reference into low power in Sleep.
// - Regulator low-power select clear keeps the regulator in normal mode in Sleep.
// - Bits 7 to 2 of the regulator control register read as zero.
// - Bit 0 of the regulator control register reads as one and software keeps it set.
// - With idle select set, the sleep instruction stops only the CPU clock.
// - With idle select clear, the sleep instruction enters full Sleep.
// - Doze active runs the CPU at the doze ratio, otherwise every cycle runs.
// - Recover on interrupt clears doze active at interrupt entry.
// - Doze on return sets doze active on the return-from-interrupt instruction.
// - The three-bit ratio code selects 1:2 up to 1:256 in powers of two.
// - Debug entry forces full speed without altering the stored doze active bit.
// - Bit 3 of the doze and idle register reads as zero.
// - Any interrupt ends Idle regardless of global enable and idle select is kept.
// - A watchdog timeout in Idle wakes the device instead of resetting it.
// - Waking from low-power Sleep inserts an extra stabilisation delay.
module dipc_top #(
	parameter int LP_WAKE_CYC = dipc_pkg::DIPC_LP_WAKE_CYC
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic por_rst,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire dipc_pkg::dipc_evt_t evt,
	output logic cpu_clk_en,
	output logic cpu_cycle_en,
	output logic periph_clk_en,
	output logic regulator_low_power,
	output logic wdt_reset_block,
	output logic wake_pulse
);
	import dipc_pkg::*;

	dipc_state_t state_q;
	dipc_ctrl_t ctrl_q;
	logic reg_lp_q;
	logic [1:0] phase_q;
	logic [15:0] wait_q;
	logic periph_tick;
	logic div_en;
	logic debug_q;
	logic [7:0] rdata_d;
	logic wake_q;
	logic idle_sel_q;
	logic doze_act_q;
	logic recover_q;
	logic doze_ret_q;
	logic [2:0] ratio_q;

	// One flop per field keeps every bit under a single process
	assign ctrl_q = {idle_sel_q, doze_act_q, recover_q, doze_ret_q, ratio_q};

	// Rule 17 form: por_rst clears all, rst clears all but idle select
	always_ff @(posedge mclk) begin
		if (por_rst) begin
			idle_sel_q <= DIPC_DOZE_IDLE_RST[DIPC_IDLE_BIT];
		end else if (reg_wr && reg_addr == DIPC_ADDR_DOZE_IDLE) begin
			idle_sel_q <= reg_wdata[DIPC_IDLE_BIT];
		end
	end

	always_ff @(posedge mclk) begin
		if (por_rst || rst) begin
			recover_q <= DIPC_DOZE_IDLE_RST[DIPC_RECOVER_BIT];
			doze_ret_q <= DIPC_DOZE_IDLE_RST[DIPC_RETURN_BIT];
			ratio_q <= DIPC_DOZE_IDLE_RST[DIPC_RATIO_LSB +: 3];
			reg_lp_q <= DIPC_REG_CTRL_RST[DIPC_REG_LP_BIT];
		end else if (reg_wr) begin
			if (reg_addr == DIPC_ADDR_DOZE_IDLE) begin
				recover_q <= reg_wdata[DIPC_RECOVER_BIT];
				doze_ret_q <= reg_wdata[DIPC_RETURN_BIT];
				ratio_q <= reg_wdata[DIPC_RATIO_LSB +: 3];
			end
			if (reg_addr == DIPC_ADDR_REG_CTRL) begin
				reg_lp_q <= reg_wdata[DIPC_REG_LP_BIT];
			end
		end
	end

	// Hardware set/clear beats a same-cycle software write
	always_ff @(posedge mclk) begin
		if (por_rst || rst) begin
			doze_act_q <= DIPC_DOZE_IDLE_RST[DIPC_DOZE_BIT];
		end else if (evt.return_from_irq_op && doze_ret_q) begin
			doze_act_q <= 1'b1;
		end else if (evt.irq_entry && recover_q) begin
			doze_act_q <= 1'b0;
		end else if (reg_wr && reg_addr == DIPC_ADDR_DOZE_IDLE) begin
			doze_act_q <= reg_wdata[DIPC_DOZE_BIT];
		end
	end

	always_ff @(posedge mclk) begin
		if (por_rst || rst) begin
			debug_q <= 1'b0;
		end else if (evt.in_circuit_debug_entry) begin
			debug_q <= 1'b1;
		end
	end

	// Power state sequencing
	always_ff @(posedge mclk) begin
		if (por_rst || rst) begin
			state_q <= DIPC_RUN;
			wait_q <= 16'h0000;
		end else begin
			case (state_q)
				DIPC_RUN: begin
					if (evt.sleep_op && !evt.irq_pending) begin
						state_q <= ctrl_q.idle_select ? DIPC_IDLE : DIPC_SLEEP;
					end
				end
				DIPC_IDLE: begin
					if (evt.irq_pending || evt.wdt_timeout) begin
						state_q <= DIPC_RUN;
					end
				end
				DIPC_SLEEP: begin
					if (evt.irq_pending || evt.wdt_timeout) begin
						if (reg_lp_q) begin
							state_q <= DIPC_WAKE;
							wait_q <= 16'(LP_WAKE_CYC - 1);
						end else begin
							state_q <= DIPC_RUN;
						end
					end
				end
				DIPC_WAKE: begin
					if (wait_q == 16'h0000) begin
						state_q <= DIPC_RUN;
					end else begin
						wait_q <= wait_q - 16'h0001;
					end
				end
				default: begin
					state_q <= DIPC_RUN;
				end
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (por_rst || rst) begin
			wake_q <= 1'b0;
		end else begin
			wake_q <= (state_q == DIPC_IDLE && (evt.irq_pending || evt.wdt_timeout)) ||
				(state_q == DIPC_WAKE && wait_q == 16'h0000) ||
				(state_q == DIPC_SLEEP && !reg_lp_q && (evt.irq_pending || evt.wdt_timeout));
		end
	end
	assign wake_pulse = wake_q;

	// Peripheral instruction cycle is four system clocks
	always_ff @(posedge mclk) begin
		if (por_rst || rst) begin
			phase_q <= 2'h0;
		end else begin
			phase_q <= phase_q + 2'h1;
		end
	end
	assign periph_tick = (phase_q == DIPC_PHASE_LAST) && (state_q == DIPC_RUN);

	dipc_doze_div u_div (
		.mclk(mclk),
		.rst(por_rst || rst),
		.periph_tick(periph_tick),
		.doze_on(ctrl_q.doze_active && !debug_q),
		.ratio(ctrl_q.ratio),
		.cycle_en(div_en)
	);
	assign cpu_cycle_en = div_en;
	assign cpu_clk_en = (state_q == DIPC_RUN);
	assign periph_clk_en = (state_q != DIPC_SLEEP) && (state_q != DIPC_WAKE);
	assign regulator_low_power = reg_lp_q && (state_q == DIPC_SLEEP);
	// Timeout while idle becomes a wake, never a reset
	assign wdt_reset_block = (state_q == DIPC_IDLE);

	always_comb begin
		rdata_d = 8'h00;
		case (reg_addr)
			DIPC_ADDR_REG_CTRL: begin
				rdata_d[DIPC_REG_ONE_BIT] = 1'b1;
				rdata_d[DIPC_REG_LP_BIT] = reg_lp_q;
			end
			DIPC_ADDR_DOZE_IDLE: begin
				rdata_d[DIPC_IDLE_BIT] = ctrl_q.idle_select;
				rdata_d[DIPC_DOZE_BIT] = ctrl_q.doze_active;
				rdata_d[DIPC_RECOVER_BIT] = ctrl_q.recover_on_irq;
				rdata_d[DIPC_RETURN_BIT] = ctrl_q.doze_on_return;
				rdata_d[DIPC_RATIO_LSB +: 3] = ctrl_q.ratio;
			end
			DIPC_ADDR_STATUS: begin
				rdata_d = {5'h00, debug_q, state_q};
			end
			default: begin
				rdata_d = 8'h00;
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (por_rst || rst) begin
			reg_rdata <= 8'h00;
		end else begin
			reg_rdata <= reg_rd ? rdata_d : 8'h00;
		end
	end
endmodule
`default_nettype wire
